// *** vlb_port.sv ***
// Synchronous 32-bit local bus slave port: latches address, qualifier
// and byte enables, decodes the local device, takes the direction on
// the cycle strobe, selects byte lanes and answers with ready.
// Assumes the bus pins are synchronous to lclk and the register file
// sits on clk behind the reg_* strobes.
`timescale 1ns/10ps
// Function
// (R1) Address passes while strobe low, held from its rising edge.
// (R2) Decode valid only while access qualifier low, latched like address.
// (R3) Direction sampled on first bus clock with cycle strobe active.
// (R4) Board makes cycle strobe from address strobe one clock later.
// (R5) Byte enables pass while strobe low, held for the access.
// (R6) Enables 0000 dword, 1100 low word, 0011 high word.
// (R7) Single low enable selects one byte lane only.
// (R8) Unselected lanes float on reads and are ignored on writes.
// (R9) Upper byte enables override address bit one, tied low.
// (R10) Local device output driven both ways, active on valid decode.
// (R11) Dword only to the data window; other registers byte or word.
// (R12) All bus transactions happen on rising bus clock edges.
// (R13) Glue makes the bus ready line from the sync ready output.
// (R14) Board inverts the bus reset into the active high reset.
// (R15) Board ties unused async strobes, bit one and type select.
module vlb_port #(
  parameter logic [11:0] IO_BASE = vlb_pkg::IO_BASE_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lclk,
  input wire logic addr_strobe_n,
  input wire logic cycle_strobe_n,
  input wire logic [vlb_pkg::ADDR_HI:vlb_pkg::ADDR_LO] addr_in,
  input wire logic access_qualify,
  input wire logic direction_in,
  input wire logic [3:0] byte_enables_n,
  input wire logic bus_type_select_n,
  input wire logic rdy_return_n,
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic [3:0] data_oe,
  output logic sync_ready_out_n,
  output logic local_device_out_n,
  output logic reg_req,
  output logic reg_write,
  output logic [1:0] reg_idx,
  output logic [3:0] reg_be_n,
  output logic [31:0] reg_wdata,
  output logic width_fault,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata
);
  import vlb_pkg::*;

  localparam int LANES = 4;
  localparam int LANE_W = 8;

  vlb_xfer_if xf ();

  // Link reset, brought over from the core clock
  logic [SYNC_STAGES-1:0] lrst_sync_ff;
  logic lrst;

  // Bus type strap, a static board level
  logic [SYNC_STAGES-1:0] vl_sel_sync_ff;
  logic vl_mode;

  // Address phase holding registers
  logic [ADDR_HI:ADDR_LO] addr_hold_ff;
  logic aq_hold_ff;
  logic [3:0] be_hold_ff;
  logic [ADDR_HI:ADDR_LO] eff_addr;
  logic eff_aq;
  logic [3:0] eff_be_n;

  // Decode
  logic dev_hit;
  logic [1:0] eff_idx;
  vlb_size_t eff_size;
  logic [3:0] lane_sel;
  logic wide_bad;
  logic start_cycle;
  logic take_cycle;

  // Access state
  vlb_lstate_t lst_ff;
  logic wr_ff;
  logic wide_ff;
  logic [1:0] idx_ff;
  logic [3:0] be_ff;
  logic [31:0] wdata_ff;
  logic req_tgl_ff;
  logic [SYNC_STAGES-1:0] ack_sync_ff;
  logic ack_done;

  // Bus answer
  logic [31:0] rd_ff;
  logic [3:0] oe_ff;
  logic srdy_n_ff;

  // Link reset synchroniser
  always_ff @(posedge lclk) begin
    lrst_sync_ff <= {lrst_sync_ff[0], sys_rst};
  end

  assign lrst = lrst_sync_ff[1];

  // Strap synchroniser
  always_ff @(posedge lclk) begin
    if (lrst) begin
      vl_sel_sync_ff <= '1;
    end else begin
      vl_sel_sync_ff <= {vl_sel_sync_ff[0], bus_type_select_n};
    end
  end

  assign vl_mode = ~vl_sel_sync_ff[1];

  // Address, qualifier and enables follow the pins while the strobe
  // is low; the last sample stands once the strobe has risen.
  always_ff @(posedge lclk) begin // R12
    if (lrst) begin
      addr_hold_ff <= '0;
    end else if (!addr_strobe_n) begin
      addr_hold_ff <= addr_in; // R1
    end
  end

  // Qualifier resets to its idle level, so nothing decodes after reset
  always_ff @(posedge lclk) begin
    if (lrst) begin
      aq_hold_ff <= 1'b1;
    end else if (!addr_strobe_n) begin
      aq_hold_ff <= access_qualify; // R2
    end
  end

  always_ff @(posedge lclk) begin
    if (lrst) begin
      be_hold_ff <= BE_NONE;
    end else if (!addr_strobe_n) begin
      be_hold_ff <= byte_enables_n; // R5
    end
  end

  assign eff_addr = addr_strobe_n ? addr_hold_ff : addr_in; // R1
  assign eff_aq = addr_strobe_n ? aq_hold_ff : access_qualify; // R2
  assign eff_be_n = addr_strobe_n ? be_hold_ff : byte_enables_n; // R5

  // Local device decode on the upper address bits
  assign dev_hit = vl_mode
                   && (eff_addr[ADDR_HI:DEC_LO] == IO_BASE)
                   && !eff_aq; // R10 R2

  // Totem pole: driven high and low, never floated
  assign local_device_out_n = ~dev_hit; // R10

  // Register index inside the window; bit one is absent and the
  // upper enables stand in for it.
  assign eff_idx = eff_addr[DEC_LO-1:ADDR_LO]; // R9

  // Access size from the enable pattern
  always_comb begin
    unique case (eff_be_n)
      BE_DWORD: eff_size = VLB_SZ_DWORD; // R6
      BE_WORD_LO,
      BE_WORD_HI: eff_size = VLB_SZ_WORD; // R6
      BE_BYTE0,
      BE_BYTE1,
      BE_BYTE2,
      BE_BYTE3: eff_size = VLB_SZ_BYTE; // R7
      default: eff_size = VLB_SZ_BAD;
    endcase
  end

  // Per lane: select, write capture, read capture and lane drive
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign lane_sel[g] = ~eff_be_n[g]; // R7 R8

      // Unselected write lanes are dropped
      always_ff @(posedge lclk) begin
        if (lrst) begin
          wdata_ff[g*LANE_W +: LANE_W] <= '0;
        end else if (take_cycle) begin
          wdata_ff[g*LANE_W +: LANE_W] <= lane_sel[g]
                                          ? data_in[g*LANE_W +: LANE_W]
                                          : '0; // R8
        end
      end

      // Read data is taken as the core answers
      always_ff @(posedge lclk) begin
        if (lrst) begin
          rd_ff[g*LANE_W +: LANE_W] <= '0;
        end else if (lst_ff == VLB_L_WAIT && ack_done) begin
          rd_ff[g*LANE_W +: LANE_W] <= xf.rdata[g*LANE_W +: LANE_W];
        end
      end

      // A lane drives only on reads that enable it
      always_ff @(posedge lclk) begin
        if (lrst) begin
          oe_ff[g] <= 1'b0;
        end else if (lst_ff == VLB_L_WAIT && ack_done) begin
          oe_ff[g] <= !wr_ff && !be_ff[g]; // R8
        end else if (lst_ff == VLB_L_RDY && !rdy_return_n) begin
          oe_ff[g] <= 1'b0;
        end else if (lst_ff == VLB_L_IDLE) begin
          oe_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Dword accesses are only legal on the data window
  assign wide_bad = (eff_size == VLB_SZ_DWORD)
                    && (eff_idx != DATA_WIN_IDX); // R11

  // First bus clock with the cycle strobe low starts the access
  assign start_cycle = !cycle_strobe_n && dev_hit; // R3 R4

  // Only an idle port takes a new access
  assign take_cycle = (lst_ff == VLB_L_IDLE) && start_cycle; // R3

  // Acknowledge toggle from the core side
  always_ff @(posedge lclk) begin
    if (lrst) begin
      ack_sync_ff <= '0;
    end else begin
      ack_sync_ff <= {ack_sync_ff[0], xf.ack_tgl};
    end
  end

  assign ack_done = (ack_sync_ff[1] == req_tgl_ff);

  // Access sequencer
  always_ff @(posedge lclk) begin // R12
    if (lrst) begin
      lst_ff <= VLB_L_IDLE;
    end else begin
      unique case (lst_ff)
        VLB_L_IDLE: begin
          if (start_cycle) begin
            lst_ff <= VLB_L_WAIT;
          end
        end
        VLB_L_WAIT: begin
          if (ack_done) begin
            lst_ff <= VLB_L_RDY;
          end
        end
        VLB_L_RDY: begin
          if (!rdy_return_n) begin
            lst_ff <= VLB_L_END;
          end
        end
        VLB_L_END: begin
          if (cycle_strobe_n) begin
            lst_ff <= VLB_L_IDLE;
          end
        end
      endcase
    end
  end

  // Direction and fault are taken on the first cycle strobe clock
  always_ff @(posedge lclk) begin
    if (lrst) begin
      wr_ff <= 1'b0;
    end else if (take_cycle) begin
      wr_ff <= direction_in; // R3
    end
  end

  always_ff @(posedge lclk) begin
    if (lrst) begin
      wide_ff <= 1'b0;
    end else if (take_cycle) begin
      wide_ff <= wide_bad; // R11
    end
  end

  // Index and enables stay still until the core answers
  always_ff @(posedge lclk) begin
    if (lrst) begin
      idx_ff <= '0;
    end else if (take_cycle) begin
      idx_ff <= eff_idx;
    end
  end

  always_ff @(posedge lclk) begin
    if (lrst) begin
      be_ff <= BE_NONE;
    end else if (take_cycle) begin
      be_ff <= eff_be_n;
    end
  end

  // Request toggle; fields above stay still until the answer
  always_ff @(posedge lclk) begin
    if (lrst) begin
      req_tgl_ff <= 1'b0;
    end else if (lst_ff == VLB_L_IDLE && start_cycle) begin
      req_tgl_ff <= ~req_tgl_ff;
    end
  end

  assign xf.req_tgl = req_tgl_ff;
  assign xf.wr = wr_ff;
  assign xf.wide_fault = wide_ff;
  assign xf.idx = idx_ff;
  assign xf.be_n = be_ff;
  assign xf.wdata = wdata_ff;

  assign data_out = rd_ff;
  assign data_oe = oe_ff; // R8

  // Ready stays low through the answer phase
  always_ff @(posedge lclk) begin
    if (lrst) begin
      srdy_n_ff <= 1'b1;
    end else if (lst_ff == VLB_L_WAIT && ack_done) begin
      srdy_n_ff <= 1'b0;
    end else if (lst_ff == VLB_L_RDY && !rdy_return_n) begin
      srdy_n_ff <= 1'b1;
    end
  end

  // Glue turns this into the open drain bus ready
  assign sync_ready_out_n = srdy_n_ff; // R13

  vlb_core_side u_core (
    .clk(clk),
    .sys_rst(sys_rst), // R14
    .xf(xf.core),
    .reg_req(reg_req),
    .reg_write(reg_write),
    .reg_idx(reg_idx),
    .reg_be_n(reg_be_n),
    .reg_wdata(reg_wdata),
    .width_fault(width_fault),
    .reg_ack(reg_ack),
    .reg_rdata(reg_rdata)
  );
endmodule

// *** vlb_pkg.sv ***
// Package for the local bus slave port: widths, byte enable codes,
// access sizes and state types.
// Assumes nothing beyond a SystemVerilog compiler.
package vlb_pkg;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 2;
  localparam int DEC_LO = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [11:0] IO_BASE_DEF = 12'h030;
  localparam logic [1:0] DATA_WIN_IDX = 2'h2;
  localparam logic [3:0] BE_DWORD = 4'h0;
  localparam logic [3:0] BE_WORD_LO = 4'hC;
  localparam logic [3:0] BE_WORD_HI = 4'h3;
  localparam logic [3:0] BE_BYTE0 = 4'hE;
  localparam logic [3:0] BE_BYTE1 = 4'hD;
  localparam logic [3:0] BE_BYTE2 = 4'hB;
  localparam logic [3:0] BE_BYTE3 = 4'h7;
  localparam logic [3:0] BE_NONE = 4'hF;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    VLB_SZ_DWORD,
    VLB_SZ_WORD,
    VLB_SZ_BYTE,
    VLB_SZ_BAD
  } vlb_size_t;
  typedef enum {
    VLB_L_IDLE,
    VLB_L_WAIT,
    VLB_L_RDY,
    VLB_L_END
  } vlb_lstate_t;
  typedef enum {
    VLB_C_IDLE,
    VLB_C_BUSY
  } vlb_cstate_t;
endpackage

// *** vlb_xfer_if.sv ***
// Carrier between the link side and the core side of the port.
// Toggle handshake: fields stay stable while req_tgl differs from ack_tgl.
`timescale 1ns/10ps
interface vlb_xfer_if;
  logic req_tgl;
  logic ack_tgl;
  logic wr;
  logic wide_fault;
  logic [1:0] idx;
  logic [3:0] be_n;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport link (
    output req_tgl, wr, wide_fault, idx, be_n, wdata,
    input ack_tgl, rdata
  );
  modport core (
    input req_tgl, wr, wide_fault, idx, be_n, wdata,
    output ack_tgl, rdata
  );
endinterface

// *** vlb_core_side.sv ***
// Core clock side of the port: turns link requests into register
// strobes and returns read data.
// Assumes fields on the carrier are stable while a request is pending.
`timescale 1ns/10ps
module vlb_core_side (
  input wire logic clk,
  input wire logic sys_rst,
  vlb_xfer_if.core xf,
  output logic reg_req,
  output logic reg_write,
  output logic [1:0] reg_idx,
  output logic [3:0] reg_be_n,
  output logic [31:0] reg_wdata,
  output logic width_fault,
  input wire logic reg_ack,
  input wire logic [31:0] reg_rdata
);
  import vlb_pkg::*;
  logic [SYNC_STAGES-1:0] req_sync_ff;
  logic req_seen_ff;
  logic ack_tgl_ff;
  logic [31:0] rdata_ff;
  logic new_req;
  vlb_cstate_t cst_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      req_sync_ff <= '0;
      req_seen_ff <= 1'b0;
    end else begin
      req_sync_ff <= {req_sync_ff[0], xf.req_tgl};
      req_seen_ff <= req_sync_ff[1];
    end
  end

  assign new_req = req_sync_ff[1] ^ req_seen_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cst_ff <= VLB_C_IDLE;
      reg_req <= 1'b0;
      width_fault <= 1'b0;
      ack_tgl_ff <= 1'b0;
      rdata_ff <= DATA_ZERO;
      reg_write <= 1'b0;
      reg_idx <= 2'h0;
      reg_be_n <= BE_NONE;
      reg_wdata <= DATA_ZERO;
    end else begin
      reg_req <= 1'b0;
      width_fault <= 1'b0;
      unique case (cst_ff)
        VLB_C_IDLE: begin
          if (new_req && xf.wide_fault) begin
            // Dword to a narrow register: no register cycle
            width_fault <= 1'b1; // R11
            ack_tgl_ff <= ~ack_tgl_ff;
          end else if (new_req) begin
            reg_req <= 1'b1;
            reg_write <= xf.wr;
            reg_idx <= xf.idx;
            reg_be_n <= xf.be_n;
            reg_wdata <= xf.wdata;
            cst_ff <= VLB_C_BUSY;
          end
        end
        VLB_C_BUSY: begin
          if (reg_ack) begin
            rdata_ff <= reg_rdata;
            ack_tgl_ff <= ~ack_tgl_ff;
            cst_ff <= VLB_C_IDLE;
          end
        end
      endcase
    end
  end

  assign xf.ack_tgl = ack_tgl_ff;
  assign xf.rdata = rdata_ff;
endmodule

// *** vlb_port_props.sv ***
// Checker for the local bus slave port, bound into its top module.
// Assumes the strap input stays low while the bus is in use.
`timescale 1ns/10ps
module vlb_port_props
  import vlb_pkg::*;
#(
  parameter logic [11:0] IO_BASE = IO_BASE_DEF
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lclk,
  input wire logic addr_strobe_n,
  input wire logic cycle_strobe_n,
  input wire logic [15:2] addr_in,
  input wire logic access_qualify,
  input wire logic direction_in,
  input wire logic [3:0] byte_enables_n,
  input wire logic rdy_return_n,
  input wire logic [3:0] data_oe,
  input wire logic sync_ready_out_n,
  input wire logic local_device_out_n,
  input wire logic reg_req,
  input wire logic reg_write,
  input wire logic [1:0] reg_idx,
  input wire logic [3:0] reg_be_n,
  input wire logic width_fault
);
  logic [3:0] be_q;
  logic [1:0] ix_q;
  logic hit_q;
  logic dir_q;
  logic cyc_q;
  logic [3:0] lrst_q;
  wire hit_now = addr_in[15:4] == IO_BASE && !access_qualify;
  // Bus side leaves reset a few bus clocks after sys_rst falls
  always_ff @(posedge lclk) begin
    if (sys_rst)
      lrst_q <= 4'hF;
    else
      lrst_q <= {lrst_q[2:0], 1'b0};
  end
  wire lbus_rst = sys_rst || lrst_q != 4'h0;
  always_ff @(posedge lclk) begin
    if (sys_rst)
      hit_q <= 1'b0;
    else if (!addr_strobe_n)
      hit_q <= hit_now;
  end
  always_ff @(posedge lclk) begin
    if (!addr_strobe_n) begin
      be_q <= byte_enables_n;
      ix_q <= addr_in[3:2];
    end
  end
  always_ff @(posedge lclk) begin
    cyc_q <= cycle_strobe_n;
    if (!cycle_strobe_n && cyc_q)
      dir_q <= direction_in;
  end
  sequence s_start;
    $fell(cycle_strobe_n) && hit_q;
  endsequence
  sequence s_ret;
    !sync_ready_out_n && !rdy_return_n;
  endsequence
  a_ldev_decode: assert property (@(posedge lclk) disable iff (lbus_rst)
    local_device_out_n == !(addr_strobe_n ? hit_q : hit_now))
    else $error("local device output off decode");
  a_miss_quiet: assert property (@(posedge lclk) disable iff (sys_rst)
    !cycle_strobe_n && !hit_q |-> sync_ready_out_n && data_oe == 4'h0)
    else $error("answer to a missed decode");
  a_rdy_bound: assert property (@(posedge lclk) disable iff (sys_rst)
    s_start |-> ##[1:40] !sync_ready_out_n)
    else $error("ready never came");
  a_rdy_release: assert property (@(posedge lclk) disable iff (sys_rst)
    s_ret |=> sync_ready_out_n && data_oe == 4'h0)
    else $error("ready or lanes not released");
  a_oe_lanes: assert property (@(posedge lclk) disable iff (sys_rst)
    data_oe != 4'h0 |-> data_oe == ~be_q && !dir_q)
    else $error("driven lanes differ from enables");
  a_req_fields: assert property (@(posedge clk) disable iff (sys_rst)
    reg_req |-> reg_write == dir_q && reg_idx == ix_q && reg_be_n == be_q)
    else $error("request fields differ from bus");
  a_fault_dword: assert property (@(posedge clk) disable iff (sys_rst)
    width_fault |-> !reg_req && be_q == BE_DWORD && ix_q != DATA_WIN_IDX)
    else $error("width fault without cause");
  a_dword_window: assert property (@(posedge clk) disable iff (sys_rst)
    reg_req |-> be_q != BE_DWORD || ix_q == DATA_WIN_IDX)
    else $error("dword request outside data window");
endmodule
bind vlb_port vlb_port_props #(.IO_BASE(IO_BASE)) i_vlb_port_props (
  .clk(clk), .sys_rst(sys_rst), .lclk(lclk),
  .addr_strobe_n(addr_strobe_n), .cycle_strobe_n(cycle_strobe_n),
  .addr_in(addr_in), .access_qualify(access_qualify),
  .direction_in(direction_in), .byte_enables_n(byte_enables_n),
  .rdy_return_n(rdy_return_n), .data_oe(data_oe),
  .sync_ready_out_n(sync_ready_out_n),
  .local_device_out_n(local_device_out_n), .reg_req(reg_req),
  .reg_write(reg_write), .reg_idx(reg_idx), .reg_be_n(reg_be_n),
  .width_fault(width_fault)
);

// *** vlb_host.sv ***
// Bus master model with its glue: one access at a time on lclk.
// Assumes ready goes straight back to the master.
`timescale 1ns/10ps
module vlb_host (
  input wire logic lclk,
  output logic addr_strobe_n,
  output logic cycle_strobe_n,
  output logic [15:2] addr_in,
  output logic access_qualify,
  output logic direction_in,
  output logic [3:0] byte_enables_n,
  output logic rdy_return_n,
  output logic [31:0] data_in,
  input wire logic [31:0] data_out,
  input wire logic [3:0] data_oe,
  input wire logic sync_ready_out_n
);
  initial begin
    addr_strobe_n = 1'b1;
    cycle_strobe_n = 1'b1;
    addr_in = '1;
    access_qualify = 1'b1;
    direction_in = 1'b0;
    byte_enables_n = 4'hF;
    rdy_return_n = 1'b1;
    data_in = 32'h0F0F_0F0F;
  end
  task automatic access(input logic [15:2] a, input logic q,
      input logic [3:0] be, input logic wr, input logic [31:0] wd,
      input int stall, output logic [31:0] rd, output logic ok);
    int n;
    @(posedge lclk);
    #1;
    addr_in = a;
    access_qualify = q;
    byte_enables_n = be;
    direction_in = wr;
    data_in = wr ? wd : ~data_in;
    addr_strobe_n = 1'b0;
    @(posedge lclk);
    #1;
    addr_strobe_n = 1'b1;
    cycle_strobe_n = 1'b0;
    @(posedge lclk);
    #1;
    // Released lines other than the qualifier show garbage, never the old value; the qualifier goes high
    addr_in = ~a;
    byte_enables_n = ~be;
    direction_in = ~wr;
    access_qualify = 1'b1;
    data_in = ~data_in;
    n = 0;
    while (sync_ready_out_n !== 1'b0 && n < 40) begin
      @(posedge lclk);
      #1;
      n++;
    end
    ok = n < 40;
    rd = 32'hZZZZ_ZZZZ;
    if (ok) begin
      repeat (stall) begin
        @(posedge lclk);
        #1;
      end
      for (int i = 0; i < 4; i++)
        if (data_oe[i] === 1'b1)
          rd[8*i+:8] = data_out[8*i+:8];
      rdy_return_n = 1'b0;
      @(posedge lclk);
      #1;
      rdy_return_n = 1'b1;
    end
    cycle_strobe_n = 1'b1;
  endtask
endmodule

// *** vlb_port_tb.sv ***
// Testbench for the local bus slave port.
// Assumes the host model and a register file responder in this module.
`timescale 1ns/10ps
module vlb_port_tb;
  import vlb_pkg::*;
  localparam logic [11:0] BASE = 12'h1A5;
  localparam logic [3:0] BES [6] = '{BE_WORD_LO, BE_WORD_HI, BE_BYTE0,
    BE_BYTE1, BE_BYTE2, BE_BYTE3};
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_ack = 1'b0;
  logic [31:0] reg_rdata = 32'h0;
  logic as_n, cs_n, aq, dir, rr_n, srdy_n, ldev_n, req, wr, wf, w_q;
  logic [15:2] addr;
  logic [3:0] be_n, oe, rbe_n, b_q;
  logic [31:0] din, dout, rwd, rval, d_q;
  logic [1:0] ridx, i_q;
  int req_n = 0;
  int wf_n = 0;
  int fail_count = 0;
  int checks = 0;
  always #10 clk = ~clk;
  always #24 lclk = ~lclk;
  vlb_port #(.IO_BASE(BASE)) i_vlb_port (.clk(clk), .sys_rst(sys_rst),
    .lclk(lclk), .addr_strobe_n(as_n), .cycle_strobe_n(cs_n),
    .addr_in(addr), .access_qualify(aq), .direction_in(dir),
    .byte_enables_n(be_n), .bus_type_select_n(1'b0),
    .rdy_return_n(rr_n), .data_in(din), .data_out(dout), .data_oe(oe),
    .sync_ready_out_n(srdy_n),
    .local_device_out_n(ldev_n), .reg_req(req), .reg_write(wr),
    .reg_idx(ridx), .reg_be_n(rbe_n), .reg_wdata(rwd), .width_fault(wf),
    .reg_ack(reg_ack), .reg_rdata(reg_rdata));
  vlb_host i_vlb_host (.lclk(lclk), .addr_strobe_n(as_n),
    .cycle_strobe_n(cs_n), .addr_in(addr), .access_qualify(aq),
    .direction_in(dir), .byte_enables_n(be_n), .rdy_return_n(rr_n),
    .data_in(din), .data_out(dout), .data_oe(oe), .sync_ready_out_n(srdy_n));
  // Register file: answers each request three clocks later
  initial forever begin
    @(posedge clk);
    if (req === 1'b1) begin
      req_n++;
      w_q = wr;
      i_q = ridx;
      b_q = rbe_n;
      d_q = rwd;
      repeat (3) @(posedge clk);
      #1;
      reg_ack = 1'b1;
      reg_rdata = rval;
      @(posedge clk);
      #1;
      reg_ack = 1'b0;
      reg_rdata = ~rval;
    end
  end
  always @(posedge clk) if (wf === 1'b1) wf_n++;
  task stop_test;
    $display("comparisons %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] lanes(input logic [3:0] b,
      input logic [31:0] v, input logic z);
    for (int i = 0; i < 4; i++)
      lanes[8*i+:8] = !b[i] ? v[8*i+:8] : (z ? 8'hZZ : 8'h00);
  endfunction
  task automatic xfer(input logic [15:2] a, input logic q,
      input logic [3:0] b, input logic w, input logic [31:0] wd,
      input int st, input logic eo, output logic [31:0] rd);
    logic ok;
    i_vlb_host.access(a, q, b, w, wd, st, rd, ok);
    chk({31'h0, ok}, {31'h0, eo});
    if (ok !== eo)
      stop_test();
  endtask
  task t_dword;
    logic [31:0] rd;
    rval = 32'hC3A5_5A3C;
    xfer({BASE, DATA_WIN_IDX}, 1'b0, BE_DWORD, 1'b1, 32'h1234_5678, 0,
      1'b1, rd);
    chk({31'h0, w_q}, 32'h1);
    chk({30'h0, i_q}, {30'h0, DATA_WIN_IDX});
    chk({28'h0, b_q}, {28'h0, BE_DWORD});
    chk(d_q, 32'h1234_5678);
    xfer({BASE, DATA_WIN_IDX}, 1'b0, BE_DWORD, 1'b0, 32'h0, 2, 1'b1,
      rd);
    chk({31'h0, w_q}, 32'h0);
    chk(rd, rval);
  endtask
  task t_lanes;
    logic [31:0] rd;
    for (int k = 0; k < 6; k++) begin
      rval = 32'h5A6B_7C8D + k;
      xfer({BASE, 2'h0}, 1'b0, BES[k], 1'b1, 32'hA1B2_C3D4, 1, 1'b1, rd);
      chk({28'h0, b_q}, {28'h0, BES[k]});
      chk(d_q, lanes(BES[k], 32'hA1B2_C3D4, 1'b0));
      xfer({BASE, 2'h0}, 1'b0, BES[k], 1'b0, 32'h0, 3, 1'b1, rd);
      chk(rd, lanes(BES[k], rval, 1'b1));
    end
  endtask
  task t_fault;
    logic [31:0] rd;
    int n0;
    int f0;
    n0 = req_n;
    f0 = wf_n;
    xfer({BASE, 2'h1}, 1'b0, BE_DWORD, 1'b1, 32'h0BAD_F00D, 0, 1'b1,
      rd);
    chk(req_n, n0);
    chk(wf_n, f0 + 1);
  endtask
  task t_miss;
    logic [31:0] rd;
    int n0;
    n0 = req_n;
    xfer({BASE, DATA_WIN_IDX}, 1'b1, BE_DWORD, 1'b0, 32'h0, 0, 1'b0,
      rd);
    xfer({BASE ^ 12'h001, DATA_WIN_IDX}, 1'b0, BE_BYTE0, 1'b0, 32'h0, 0,
      1'b0, rd);
    chk(req_n, n0);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge lclk);
    t_dword();
    t_lanes();
    t_fault();
    t_miss();
    stop_test();
  end
endmodule
